/* File: byte_lane_swap.v */
// Byte lane reversal within one 32-bit word when the big-endian format is selected.
`timescale 1ns/1ps
`default_nettype none
module byte_lane_swap (
    input wire [31:0] data_i,
    input wire swap_i,
    output wire [31:0] data_o
);
    // Lane zero trades places with lane three, lane one with lane two.
    assign data_o = swap_i ? {data_i[7:0], data_i[15:8], data_i[23:16], data_i[31:24]} : data_i;
endmodule // byte_lane_swap
`default_nettype wire

/* File: coproc_map.vh */
// Register offsets, field positions, response codes and sizes of the coprocessor register bank.
`ifndef COPROC_MAP_VH
`define COPROC_MAP_VH
`define OFS_CTRL 8'h00
`define OFS_MODE 8'h04
`define OFS_STATUS 8'h08
`define OFS_LEN 8'h0C
`define OFS_PORT_A 8'h10
`define OFS_PORT_B 8'h14
`define OFS_VMCTRL 8'h18
`define OFS_VMSTAT 8'h1C
`define OFS_CURVA 8'h20
`define OFS_ERRTERM 8'h24
`define OFS_SRCXY 8'h28
`define OFS_PATXY 8'h2C
`define OFS_DSTXY 8'h30
`define OFS_DIRSTEP 8'h34
`define OFS_PIXOP 8'h38
`define OFS_OPDIM 8'h3C
`define OFS_FGCOL 8'h40
`define OFS_BGCOL 8'h44
`define NUM_STATE_WORDS 5'h12
`define LEN_A_VAL 8'h09
`define LEN_B_VAL 8'h09
`define CTRL_SUSPEND_BIT 3
`define CTRL_START_BIT 0
`define MODE_BIGEND_BIT 0
`define PIXOP_FG_SRC_BIT 0
`define PIXOP_BG_SRC_BIT 1
`define PIXOP_PAT_FG_BIT 2
`define PIXOP_LINE_BIT 3
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

/* File: coproc_state_regs.v */
// Coprocessor register bank with AXI4-Lite access and task-state save and restore.
//
// Our own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "coproc_map.vh"
module coproc_state_regs (
    input wire core_clk_i,
    input wire sys_rst_i,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire op_step_i,
    output reg busy_o,
    output reg suspended_o
);
    ////////////////////////////////////////////////////////////////////////////
    // Register storage. Index order in state_q is the save/restore order.
    // Control and mode stay outside the image and are not streamed.
    localparam NW = 18;
    reg [31:0] state_q [0:NW-1];
    reg [7:0] mode_q;
    reg [7:0] ctrl_q;
    reg [7:0] aw_addr_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;
    reg aw_have_q;
    reg w_have_q;
    reg restoring_q;
    reg saving_q;
    wire [4:0] seq_cnt;
    wire seq_done;
    wire big_end = mode_q[`MODE_BIGEND_BIT];
    // Slot indices inside the state image.
    // Slots 12 to 17 hold the remaining count and spares, so the length is fixed.
    localparam S_VMCTRL = 0;
    localparam S_VMSTAT = 1;
    localparam S_CURVA = 2;
    localparam S_ERR = 3;
    localparam S_SRC = 4;
    localparam S_PAT = 5;
    localparam S_DST = 6;
    localparam S_DIR = 7;
    localparam S_PIXOP = 8;
    localparam S_OPDIM = 9;
    localparam S_FG = 10;
    localparam S_BG = 11;
    localparam S_CNT = 12;

    ////////////////////////////////////////////////////////////////////////////
    // Address decode. Unmapped addresses answer SLVERR.
    // Ports, control, mode and status sit outside the image and decode apart.
    function integer slot_of;
        input [7:0] a;
        begin
            case (a)
                `OFS_VMCTRL: slot_of = S_VMCTRL;
                `OFS_VMSTAT: slot_of = S_VMSTAT;
                `OFS_CURVA: slot_of = S_CURVA;
                `OFS_ERRTERM: slot_of = S_ERR;
                `OFS_SRCXY: slot_of = S_SRC;
                `OFS_PATXY: slot_of = S_PAT;
                `OFS_DSTXY: slot_of = S_DST;
                `OFS_DIRSTEP: slot_of = S_DIR;
                `OFS_PIXOP: slot_of = S_PIXOP;
                `OFS_OPDIM: slot_of = S_OPDIM;
                `OFS_FGCOL: slot_of = S_FG;
                `OFS_BGCOL: slot_of = S_BG;
                default: slot_of = -1;
            endcase
        end
    endfunction

    // Direction steps and pixel operation keep their byte order in both formats.
    function no_swap;
        input [7:0] a;
        begin
            no_swap = (a == `OFS_DIRSTEP) || (a == `OFS_PIXOP);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Write and read path lane handling.
    wire [31:0] wr_swapped;
    wire [31:0] rd_swapped;
    reg [31:0] rd_raw;
    // Strobes swap exactly where the data lanes swap; otherwise a partial
    // write to an unswapped register would land in the wrong lane.
    wire wr_swap = big_end && !no_swap(aw_addr_q);
    wire rd_swap = big_end && !no_swap(s_axi_araddr);
    wire [3:0] strb_sw = wr_swap ? {w_strb_q[0], w_strb_q[1], w_strb_q[2], w_strb_q[3]}
                                 : w_strb_q;
    byte_lane_swap u_wswap (
        .data_i(w_data_q),
        .swap_i(wr_swap),
        .data_o(wr_swapped)
    );
    byte_lane_swap u_rswap (
        .data_i(rd_raw),
        .swap_i(rd_swap),
        .data_o(rd_swapped)
    );

    // A save starts at a port read outside a save, a restore at a port write
    // outside a restore; switching direction restarts the count.
    wire port_wr = (aw_addr_q == `OFS_PORT_A) || (aw_addr_q == `OFS_PORT_B);
    wire port_rd = (s_axi_araddr == `OFS_PORT_A) || (s_axi_araddr == `OFS_PORT_B);
    // A write completes once both halves are held and no response is pending.
    wire do_write = aw_have_q && w_have_q && !s_axi_bvalid;
    wire do_read = s_axi_arvalid && s_axi_arready;
    wire port_acc = (do_write && port_wr) || (do_read && port_rd);
    wire seq_begin = (do_write && port_wr && !restoring_q) || (do_read && port_rd && !saving_q);

    // Counter of double-words moved in the current sequence.
    state_seq_counter u_seq (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .clear_i(seq_begin),
        .step_i(port_acc),
        .count_o(seq_cnt),
        .done_o(seq_done)
    );
    // The first access of a sequence uses slot zero; the counter then moves to one.
    // Past the image length the counter saturates and the sequence ends, so a surplus access opens a new one at slot zero,
    // a limitation the host avoids by moving exactly the reported count.
    wire [4:0] seq_idx = seq_begin ? 5'h00 : seq_cnt;

    ////////////////////////////////////////////////////////////////////////////
    // Read data multiplexer; only listed registers read back directly.
    // The rest answer zero with OKAY and are seen only through a save.
    always @* begin
        rd_raw = 32'h00000000;
        case (s_axi_araddr)
            `OFS_CTRL: rd_raw = {24'h000000, ctrl_q};
            `OFS_MODE: rd_raw = {24'h000000, mode_q};
            `OFS_STATUS: rd_raw = {30'h00000000, suspended_o, busy_o};
            `OFS_LEN: rd_raw = {16'h0000, `LEN_B_VAL, `LEN_A_VAL};
            `OFS_PORT_A, `OFS_PORT_B: rd_raw = (seq_idx < NW) ? state_q[seq_idx] : 32'h0;
            `OFS_VMCTRL, `OFS_VMSTAT, `OFS_CURVA, `OFS_ERRTERM, `OFS_SRCXY, `OFS_PATXY,
            `OFS_DSTXY: rd_raw = state_q[slot_of(s_axi_araddr)];
            default: rd_raw = 32'h00000000;
        endcase
    end

    // Only unmapped addresses give an error response on a read.
    function rd_mapped;
        input [7:0] a;
        begin
            rd_mapped = (slot_of(a) >= 0) || (a == `OFS_CTRL) || (a == `OFS_MODE) ||
                        (a == `OFS_STATUS) || (a == `OFS_LEN) ||
                        (a == `OFS_PORT_A) || (a == `OFS_PORT_B);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite channel handshakes; address and data are taken in either order.
    // Each ready is a one-cycle pulse; the captured flags keep a held valid
    // from being taken twice before its response is raised.
    always @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_have_q && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (port_wr || (slot_of(aw_addr_q) >= 0) || aw_addr_q == `OFS_CTRL ||
                                aw_addr_q == `OFS_MODE) ? `RESP_OKAY : `RESP_SLVERR;
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (do_read) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_swapped;
                s_axi_rresp <= rd_mapped({s_axi_araddr[7:2], 2'b00}) ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control, mode and sequence flags.
    // A port write stops a running operation; the restored image replaces it.
    always @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            ctrl_q <= 8'h00;
            mode_q <= 8'h00;
            busy_o <= 1'b0;
            suspended_o <= 1'b0;
            saving_q <= 1'b0;
            restoring_q <= 1'b0;
        end else begin
            // Status lags the suspend bit by one clock, as it is registered.
            suspended_o <= ctrl_q[`CTRL_SUSPEND_BIT] && busy_o;
            if (do_write && aw_addr_q == `OFS_CTRL && strb_sw[0]) begin
                ctrl_q <= wr_swapped[7:0];
                if (wr_swapped[`CTRL_START_BIT]) begin
                    busy_o <= 1'b1;
                end
            end
            if (do_write && aw_addr_q == `OFS_MODE && strb_sw[0]) begin
                mode_q <= wr_swapped[7:0];
            end
            // An operation ends when its remaining count reaches zero.
            if (busy_o && !ctrl_q[`CTRL_SUSPEND_BIT] && op_step_i &&
                state_q[S_CNT] == 32'h00000001) begin
                busy_o <= 1'b0;
            end
            // Port traffic sets the direction of the sequence under way.
            if (do_read && port_rd) begin
                saving_q <= 1'b1;
                restoring_q <= 1'b0;
            end
            if (do_write && port_wr) begin
                restoring_q <= 1'b1;
                saving_q <= 1'b0;
                busy_o <= 1'b0;
            end
            // Readout complete: control, busy and the image return to reset; mode keeps its value.
            if (saving_q && seq_done) begin
                saving_q <= 1'b0;
                busy_o <= 1'b0;
                ctrl_q <= 8'h00;
            end
            // Restore complete: a restored operation resumes when suspend clears.
            if (restoring_q && seq_done) begin
                restoring_q <= 1'b0;
                busy_o <= (state_q[S_CNT] != 32'h00000000);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State image: host writes, restore stream and per-step pointer updates.
    // Suspend gates stepping at once; a step pulse already given is never cut,
    // so an engine memory cycle in progress still completes.
    wire running = busy_o && !ctrl_q[`CTRL_SUSPEND_BIT];
    wire [31:0] pixop = state_q[S_PIXOP];
    wire [31:0] dir = state_q[S_DIR];
    wire use_src = pixop[`PIXOP_FG_SRC_BIT] || pixop[`PIXOP_BG_SRC_BIT];
    wire use_pat = !pixop[`PIXOP_PAT_FG_BIT];
    wire is_line = pixop[`PIXOP_LINE_BIT];
    // Step direction: low half is X, high half is Y, signed steps from the direction word.
    // Limitation: each axis step is one signed byte, enough for unit moves.
    wire [31:0] xy_step = {{8{dir[15]}}, dir[15:8], {8{dir[7]}}, dir[7:0]};
    integer k;
    always @(posedge core_clk_i) begin
        if (sys_rst_i || (saving_q && seq_done)) begin
            for (k = 0; k < NW; k = k + 1) begin
                state_q[k] <= 32'h00000000;
            end
        end else if (do_write && port_wr) begin
            // Restore words land in the order in which they were read out.
            if (seq_idx < NW) begin
                state_q[seq_idx] <= wr_swapped;
            end
        end else if (do_write && slot_of(aw_addr_q) >= 0) begin
            for (k = 0; k < 4; k = k + 1) begin
                if (strb_sw[k]) begin
                    state_q[slot_of(aw_addr_q)][k*8 +: 8] <= wr_swapped[k*8 +: 8];
                end
            end
            // The top byte of the pixel operation loads the step count.
            if (aw_addr_q == `OFS_PIXOP && strb_sw[3]) begin
                state_q[S_CNT] <= {16'h0000, state_q[S_OPDIM][15:0]} + 32'h00000001;
            end
        end else if (running && op_step_i) begin
            // Other registers hold their values so operations can be repeated.
            state_q[S_CNT] <= state_q[S_CNT] - 32'h00000001;
            state_q[S_CURVA] <= state_q[S_CURVA] + 32'h00000004;
            if (is_line) begin
                state_q[S_ERR] <= state_q[S_ERR] + state_q[S_OPDIM];
            end
            if (use_src) begin
                state_q[S_SRC] <= state_q[S_SRC] + xy_step;
            end
            if (use_pat) begin
                state_q[S_PAT] <= state_q[S_PAT] + xy_step;
            end
            state_q[S_DST] <= state_q[S_DST] + xy_step;
        end
    end
endmodule // coproc_state_regs
`default_nettype wire

/* File: coproc_state_regs_properties.sv */
// Concurrent checks on the bus and operation ports of the coprocessor register bank.
`timescale 1ns/1ps
`default_nettype none
module coproc_state_regs_checker (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic op_step_i,
    input wire logic busy_o,
    input wire logic suspended_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);
    ////////////////////////////////////////////////////////////////////////////////
    // Both halves of a write are offered together, so they are taken in one cycle.
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    AST_B_AFTER_WRITE: assert property (wr_taken |-> ##[1:3] s_axi_bvalid)
        else $error("Write response missing after address and data");
    AST_R_AFTER_AR: assert property (rd_taken |=> s_axi_rvalid)
        else $error("Read data did not follow the read address");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("Read data changed before it was taken");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("Write response changed before it was taken");
    AST_AWREADY_PULSE: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("Write address ready stood longer than one cycle");
    AST_AWREADY_CAUSE: assert property ($rose(s_axi_awready) |-> $past(s_axi_awvalid))
        else $error("Write address ready without a request");
    AST_ARREADY_CAUSE: assert property (s_axi_arready |-> $past(s_axi_arvalid))
        else $error("Read address ready without a request");
    AST_SUSP_NEEDS_BUSY: assert property ($rose(suspended_o) |-> $past(busy_o))
        else $error("Suspended flag rose with no operation running");
    AST_SUSP_HOLDS: assert property (suspended_o && op_step_i && !s_axi_rvalid |=> busy_o)
        else $error("Operation ended while suspended");
    AST_QUIET_AFTER_RESET: assert property ($past(sys_rst_i) |-> !s_axi_bvalid && !s_axi_rvalid && !busy_o)
        else $error("Bank not idle after reset");
endmodule // coproc_state_regs_checker
bind coproc_state_regs coproc_state_regs_checker i_coproc_state_regs_checker (.core_clk_i,
    .sys_rst_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .op_step_i, .busy_o, .suspended_o);
`default_nettype wire

/* File: host_axi_bfm.sv */
// Host model that reaches the register bank over AXI4-Lite, one access at a time.
`timescale 1ns/1ps
`default_nettype none
module host_axi_bfm (
    input wire logic core_clk_i,
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    int stalls = 0;
    // Idle bus at time zero.
    initial begin
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = 52'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Released lines carry the inverse of their last value, so a late sample is never a match.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
        int n;
        logic aw_on, w_on, b_on;
        @(posedge core_clk_i);
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hF};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        {aw_on, w_on, b_on} = 3'h7;
        resp = 2'h3;
        for (n = 0; n < 100 && b_on; n++) begin
            @(posedge core_clk_i);
            if (aw_on && s_axi_awready) begin
                aw_on = 1'b0;
                {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
            end
            if (w_on && s_axi_wready) begin
                w_on = 1'b0;
                {s_axi_wvalid, s_axi_wdata} <= {1'b0, ~d};
            end
            if (s_axi_bvalid) begin
                b_on = 1'b0;
                resp = s_axi_bresp;
                s_axi_bready <= 1'b0;
            end
        end
        if (b_on) stalls++;
    endtask
    // Read one word; rready stays up until the data has been sampled.
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        int n;
        logic ar_on, r_on;
        @(posedge core_clk_i);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        {ar_on, r_on} = 2'h3;
        {d, resp} = 34'h0;
        for (n = 0; n < 100 && r_on; n++) begin
            @(posedge core_clk_i);
            if (ar_on && s_axi_arready) begin
                ar_on = 1'b0;
                {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
            end
            if (s_axi_rvalid) begin
                r_on = 1'b0;
                {d, resp} = {s_axi_rdata, s_axi_rresp};
                s_axi_rready <= 1'b0;
            end
        end
        if (r_on) stalls++;
    endtask
endmodule // host_axi_bfm
`default_nettype wire

/* File: state_seq_counter.v */
// Double-word sequence counter for the state save and restore stream.
`timescale 1ns/1ps
`default_nettype none
`include "coproc_map.vh"
module state_seq_counter (
    input wire core_clk_i,
    input wire sys_rst_i,
    input wire clear_i,
    input wire step_i,
    output reg [4:0] count_o,
    output wire done_o
);
    // Restarted at each sequence; the opening access already counts as one word.
    always @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            count_o <= 5'h00;
        end else if (clear_i) begin
            count_o <= {4'h0, step_i};
        end else if (step_i && !done_o) begin
            count_o <= count_o + 5'h01;
        end
    end
    assign done_o = (count_o == `NUM_STATE_WORDS);
endmodule // state_seq_counter
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench for the coprocessor register bank and its state stream.
`timescale 1ns/1ps
`default_nettype none
`include "coproc_map.vh"
module testbench;
    logic core_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic op_step_i = 1'b0;
    wire [7:0] s_axi_awaddr, s_axi_araddr;
    wire [31:0] s_axi_wdata, s_axi_rdata;
    wire [3:0] s_axi_wstrb;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    wire s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, busy_o, suspended_o;
    int miscompares = 0;
    int checks_done = 0;
    int seed = 32'hE978;
    // The bank and the host model meet on every bus signal by name.
    coproc_state_regs i_coproc_state_regs (.core_clk_i, .sys_rst_i, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .op_step_i, .busy_o, .suspended_o);
    host_axi_bfm u_host (.core_clk_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);
    // Clock of 100 MHz.
    always #5 core_clk_i = ~core_clk_i;
    ////////////////////////////////////////////////////////////////////////////////
    // Comparisons, bus helpers and expectation functions.
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        u_host.rd(a, d, r);
        chk_resp(r, `RESP_OKAY);
        chk_word(d, exp);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        u_host.wr(a, d, r);
        chk_resp(r, `RESP_OKAY);
    endtask
    task automatic rdiff(input logic [7:0] a, input logic [31:0] old);
        logic [31:0] d;
        logic [1:0] r;
        u_host.rd(a, d, r);
        chk_resp(r, `RESP_OKAY);
        chk_word({31'h0, d !== old}, 32'h1);
    endtask
    // Memory cycles are pulses one clock wide with a gap, as a real engine would give.
    task automatic step(input int n);
        int k;
        for (k = 0; k < n; k++) begin
            op_step_i <= 1'b1;
            @(posedge core_clk_i);
            op_step_i <= 1'b0;
            @(posedge core_clk_i);
        end
    endtask
    function automatic logic [31:0] bswap(input logic [31:0] v);
        return {v[7:0], v[15:8], v[23:16], v[31:24]};
    endfunction
    function automatic logic [7:0] slot(input int i);
        return 8'h24 + 8'(4 * i);
    endfunction
    function automatic logic [7:0] port(input int i);
        return i[0] ? `OFS_PORT_B : `OFS_PORT_A;
    endfunction
    // Only the error term and the pointers read back directly; the rest answer zero.
    function automatic logic [31:0] seen(input int i, input logic [31:0] v);
        return (slot(i) < `OFS_DIRSTEP) ? v : 32'h0000_0000;
    endfunction
    task automatic summarize();
        miscompares += u_host.stalls;
        $display("Checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence; the pixel-operation slot is skipped while loading since it loads the step count.
    initial begin
        logic [31:0] img [0:17];
        logic [31:0] keep [0:8];
        logic [31:0] v;
        logic [1:0] r;
        int i;
        repeat (8) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        rchk(`OFS_LEN, {16'h0000, `LEN_B_VAL, `LEN_A_VAL});
        u_host.rd(8'h80, v, r);
        chk_resp(r, `RESP_SLVERR);
        for (i = 0; i < 9; i++) keep[i] = $random(seed);
        keep[4] = 32'h0000_0101; // Unit steps.
        for (i = 0; i < 9; i++) if (i != 5) wr(slot(i), keep[i]);
        for (i = 0; i < 9; i++) if (i != 5) rchk(slot(i), seen(i, keep[i]));
        wr(`OFS_MODE, 32'h0000_0001);
        wr(`OFS_SRCXY, keep[1]);
        wr(`OFS_DIRSTEP, keep[4]);
        wr(`OFS_MODE, 32'h0000_0000);
        keep[1] = bswap(keep[1]);
        rchk(`OFS_SRCXY, keep[1]);
        for (i = 0; i < `NUM_STATE_WORDS; i++) begin
            u_host.rd(port(i), img[i], r);
            chk_word(img[i], (i > 2 && i < 12 && i != 8) ? keep[i - 3] : 32'h0);
        end
        rchk(`OFS_SRCXY, 32'h0000_0000);
        for (i = 0; i < `NUM_STATE_WORDS; i++) wr(port(i), img[i]);
        for (i = 0; i < 4; i++) rchk(slot(i), keep[i]);
        for (i = 0; i < `NUM_STATE_WORDS; i++) begin
            u_host.rd(port(i), v, r);
            chk_word(v, img[i]);
        end
        for (i = 0; i < `NUM_STATE_WORDS; i++) wr(port(i), img[i]);
        // Operation with foreground pattern and no source operand, suspended before its first step.
        wr(`OFS_OPDIM, 32'h0000_0004);
        wr(`OFS_PIXOP, 32'h0100_0004);
        wr(`OFS_CTRL, 32'h0000_0001);
        for (i = 0; i < 20 && busy_o !== 1'b1; i++) @(posedge core_clk_i);
        chk_word({31'h0, busy_o}, 32'h1);
        wr(`OFS_CTRL, 32'h0000_0008);
        for (i = 0; i < 20 && suspended_o !== 1'b1; i++) @(posedge core_clk_i);
        chk_word({31'h0, suspended_o}, 32'h1);
        step(3);
        wr(`OFS_CTRL, 32'h0000_0000);
        for (i = 0; i < 200 && busy_o !== 1'b0; i++) step(1);
        chk_word({31'h0, busy_o}, 32'h0);
        rchk(`OFS_SRCXY, keep[1]);
        rchk(`OFS_PATXY, keep[2]);
        rdiff(`OFS_DSTXY, keep[3]);
        // Line draw with source and pattern maps: every pointer moves.
        wr(`OFS_PIXOP, 32'h0100_0009);
        wr(`OFS_CTRL, 32'h0000_0001);
        for (i = 0; i < 200 && busy_o !== 1'b0; i++) step(1);
        chk_word({31'h0, busy_o}, 32'h0);
        rdiff(`OFS_ERRTERM, keep[0]);
        rdiff(`OFS_SRCXY, keep[1]);
        rdiff(`OFS_PATXY, keep[2]);
        summarize();
    end
    // Whole-run limit in case a wait never ends.
    initial begin
        #900000;
        miscompares++;
        summarize();
    end
endmodule // testbench
`default_nettype wire
